// ===== hdl/decoder_pkg.sv
// package: opcode table, field layout, register map and timing constants
// assumes 14-bit instruction words and a single 10 MHz aclk
// Function
// - file operand always read before modify and store
// - destination bit: 0 accumulator, 1 file register
// - file address picks location 0x00..0x7F
// - bit ops: opcode 13:10, bit 9:7, f 6:0
// - literal ops: opcode 13:8, 8-bit literal 7:0
// - call/jump: 11-bit target from low bits
// - page load: opcode 13:7, 7-bit literal
// - bank load: opcode 13:5, 5-bit literal
// - relative jump: 9-bit offset from low bits
// - pointer offset: pointer select plus 6-bit offset
// - pointer increment: select bit 2, mode 1:0
// - don't-care bits never change the decoded operation
// - sums run one cycle, update C, DC, Z
// - and/or with file run one cycle, Z only
// - rotates through carry, one cycle, C only
// - instruction cycle is four clock cycles
// - flow change or true skip adds NOP cycle
// - indirect access with pointer MSB adds cycle
package decoder_pkg;
  localparam int WORD_W      = 14;
  localparam int FADDR_W     = 7;
  localparam int FILE_DEPTH  = 128;
  localparam int OPB_LO      = 8;
  localparam int DEST_BIT    = 7;
  localparam int OPBIT_LO    = 10;
  localparam int BIT_LO      = 7;
  localparam int PAGE_OP_LO  = 7;
  localparam int BANK_OP_LO  = 5;
  localparam int OFF_SEL_BIT = 6;
  localparam int INC_SEL_BIT = 2;
  localparam int PTR_MSB     = 15;
  // one instruction cycle in oscillator cycles
  localparam int Q_PER_CYCLE       = 4;
  localparam logic [1:0] LAST_Q    = 2'(Q_PER_CYCLE - 1);
  localparam logic [1:0] Q_READ    = 2'h1;
  localparam logic [1:0] Q_MODIFY  = 2'h2;
  // register byte offsets
  localparam logic [7:0] REG_INSTR     = 8'h00;
  localparam logic [7:0] REG_ACC       = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_PTR0      = 8'h0C;
  localparam logic [7:0] REG_PTR1      = 8'h10;
  localparam logic [7:0] REG_FIELDS_A  = 8'h14;
  localparam logic [7:0] REG_FIELDS_B  = 8'h18;
  localparam logic [7:0] REG_FIELDS_C  = 8'h1C;
  localparam logic [7:0] REG_FILE_ADDR = 8'h20;
  localparam logic [7:0] REG_FILE_DATA = 8'h24;
  localparam int ST_CARRY = 0;
  localparam int ST_HALF  = 1;
  localparam int ST_ZERO  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [FADDR_W-1:0] PORT_BASE = 7'h00;
  typedef enum logic [4:0] {
    K_NONE, K_SUM, K_SUM_C, K_CONJ, K_DISJ, K_ROT_L, K_ROT_R, K_STORE_W,
    K_DEC_SKIP, K_INC_SKIP, K_BIT_CLR, K_BIT_SET, K_TEST_CLR, K_TEST_SET,
    K_BANK, K_PAGE, K_FLOW, K_RET_LIT, K_PTR_OFF, K_PTR_INC
  } op_kind_t;
  typedef enum logic [2:0] {
    S_IDLE  = 3'h1,
    S_EXEC  = 3'h2,
    S_EXTRA = 3'h4
  } seq_state_t;
  typedef struct packed {
    op_kind_t     kind;
    logic [5:0]   op_byte;
    logic         dest;
    logic [6:0]   faddr;
    logic [3:0]   op_bit;
    logic [2:0]   bit_idx;
    logic [7:0]   lit8;
    logic [10:0]  target;
    logic [8:0]   rel;
    logic [6:0]   op_page;
    logic [6:0]   page;
    logic [8:0]   op_bank;
    logic [4:0]   bank;
    logic         off_sel;
    logic [5:0]   off;
    logic         inc_sel;
    logic [1:0]   mode;
  } decode_t;
  // opcode table: pattern, care mask, kind
  localparam int N_OPS = 22;
  localparam logic [13:0] OP_PAT [N_OPS] = '{
    14'h0700, 14'h3D00, 14'h0500, 14'h0400, 14'h0D00, 14'h0C00, 14'h0080,
    14'h0B00, 14'h0F00, 14'h1000, 14'h1400, 14'h1800, 14'h1C00, 14'h0020,
    14'h3180, 14'h2000, 14'h3200, 14'h0008, 14'h3400, 14'h3100, 14'h0010,
    14'h3F00};
  localparam logic [13:0] OP_MSK [N_OPS] = '{
    14'h3F00, 14'h3F00, 14'h3F00, 14'h3F00, 14'h3F00, 14'h3F00, 14'h3F80,
    14'h3F00, 14'h3F00, 14'h3C00, 14'h3C00, 14'h3C00, 14'h3C00, 14'h3FE0,
    14'h3F80, 14'h3000, 14'h3E00, 14'h3FFC, 14'h3F00, 14'h3F80, 14'h3FF0,
    14'h3F00};
  localparam op_kind_t OP_KIND [N_OPS] = '{
    K_SUM, K_SUM_C, K_CONJ, K_DISJ, K_ROT_L, K_ROT_R, K_STORE_W,
    K_DEC_SKIP, K_INC_SKIP, K_BIT_CLR, K_BIT_SET, K_TEST_CLR, K_TEST_SET,
    K_BANK, K_PAGE, K_FLOW, K_FLOW, K_FLOW, K_RET_LIT, K_PTR_OFF, K_PTR_INC,
    K_PTR_OFF};
  // compare only the bits that the mask cares about
  function automatic logic op_match(input logic [13:0] w, input logic [13:0] pat,
                                    input logic [13:0] msk);
    return (w & msk) == pat;
  endfunction
endpackage

// ===== hdl/file_ram.sv
// file: file register array, one write port, two registered read ports
// assumes the caller never drives two writers at once
`timescale 1ns/1ps

module file_ram
  import decoder_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               we,
  input  wire logic [FADDR_W-1:0] waddr,
  input  wire logic [7:0]         wdata,
  input  wire logic [FADDR_W-1:0] raddr_a,
  input  wire logic [FADDR_W-1:0] raddr_b,
  output logic      [7:0]         rdata_a,
  output logic      [7:0]         rdata_b
);
  logic [7:0] mem [FILE_DEPTH];

  // read returns old data on a same-address write
  always_ff @(posedge aclk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule

// ===== hdl/field_split.sv
// file: splits a 14-bit word into every format's fields and an op kind
// assumes a registered word at its input; purely combinational
`timescale 1ns/1ps

module field_split
  import decoder_pkg::*;
(
  input  wire logic [WORD_W-1:0] word,
  output decode_t                fields
);
  logic [N_OPS-1:0] hit;
  op_kind_t         kind;

  // one masked comparator per table row
  for (genvar i = 0; i < N_OPS; i++)
  begin : g_row
    assign hit[i] = op_match(word, OP_PAT[i], OP_MSK[i]);
  end

  // rows are disjoint, so the lowest hit names the kind
  always_comb
  begin
    kind = K_NONE;
    for (int i = N_OPS - 1; i >= 0; i--)
      if (hit[i])
        kind = OP_KIND[i];
  end

  // field slices per format
  assign fields.kind    = kind;
  assign fields.op_byte = word[WORD_W-1:OPB_LO];
  assign fields.dest    = word[DEST_BIT];
  assign fields.faddr   = word[FADDR_W-1:0];
  assign fields.op_bit  = word[WORD_W-1:OPBIT_LO];
  assign fields.bit_idx = word[OPBIT_LO-1:BIT_LO];
  assign fields.lit8    = word[7:0];
  assign fields.target  = word[10:0];
  assign fields.rel     = word[8:0];
  assign fields.op_page = word[WORD_W-1:PAGE_OP_LO];
  assign fields.page    = word[PAGE_OP_LO-1:0];
  assign fields.op_bank = word[WORD_W-1:BANK_OP_LO];
  assign fields.bank    = word[BANK_OP_LO-1:0];
  assign fields.off_sel = word[OFF_SEL_BIT];
  assign fields.off     = word[OFF_SEL_BIT-1:0];
  assign fields.inc_sel = word[INC_SEL_BIT];
  assign fields.mode    = word[INC_SEL_BIT-1:0];
endmodule

// ===== hdl/mcu_instruction_decoder.sv
// file: instruction decoder top with execution sequencer and register slave
// assumes one aclk, synchronous active-low aresetn, AXI4-Lite master
`timescale 1ns/1ps

module mcu_instruction_decoder
  import decoder_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  seq_state_t         state;
  logic [1:0]         phase;
  logic [1:0]         extra_left;
  logic [WORD_W-1:0]  instr;
  decode_t            dec;
  logic [7:0]         acc;
  logic               carry;
  logic               half;
  logic               zero;
  logic [4:0]         bank;
  logic [6:0]         page;
  logic [15:0]        ptr [2];
  logic [FADDR_W-1:0] file_addr;
  logic [7:0]         operand;
  logic [7:0]         result;
  logic               res_c;
  logic               res_dc;
  logic               res_z;
  logic               skip_q;
  logic [1:0]         cycles_last;
  logic               redirect_last;
  logic [7:0]         file_q;
  logic [7:0]         bus_q;
  logic               aw_full;
  logic               w_full;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;

  // register view at a byte address
  function automatic logic [31:0] reg_view(input logic [7:0] a);
    case (a)
      REG_INSTR:     return {18'h0, instr};
      REG_ACC:       return {24'h0, acc};
      REG_STATUS:    return {operand, page, bank, dec.kind, state != S_IDLE,
                             redirect_last, cycles_last, zero, half, carry};
      REG_PTR0:      return {16'h0, ptr[0]};
      REG_PTR1:      return {16'h0, ptr[1]};
      REG_FIELDS_A:  return {3'h0, dec.lit8, dec.op_bit, dec.bit_idx, dec.faddr,
                             dec.dest, dec.op_byte};
      REG_FIELDS_B:  return {dec.bank, dec.page, dec.rel, dec.target};
      REG_FIELDS_C:  return {dec.op_bank, dec.op_page, 6'h0, dec.mode,
                             dec.inc_sel, dec.off_sel, dec.off};
      REG_FILE_ADDR: return {25'h0, file_addr};
      REG_FILE_DATA: return {24'h0, bus_q};
      default:       return 32'h0;
    endcase
  endfunction

  // address decode shared by read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= REG_FILE_DATA;
  endfunction

  // byte-lane merge of new data into an old register image
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  field_split u_split (
    .word   (instr),
    .fields (dec)
  );

  // write channel bookkeeping
  wire         aw_take     = awvalid && awready;
  wire         w_take      = wvalid && wready;
  wire         do_write    = aw_full && w_full && !bvalid;
  wire         busy        = state != S_IDLE;
  wire         wr_ok       = addr_known(aw_addr) && !busy;
  wire         bus_wr      = do_write && wr_ok;
  wire  [31:0] wr_image    = strb_merge(reg_view(aw_addr), w_data, w_strb);
  wire         next_aw     = (aw_full || aw_take) && !do_write;
  wire         next_w      = (w_full || w_take) && !do_write;
  wire         next_bvalid = do_write || (bvalid && !bready);
  wire         ar_take     = arvalid && arready;
  wire         next_rvalid = ar_take || (rvalid && !rready);

  // per-register write strobes
  wire wr_instr  = bus_wr && aw_addr == REG_INSTR;
  wire wr_acc    = bus_wr && aw_addr == REG_ACC;
  wire wr_status = bus_wr && aw_addr == REG_STATUS;
  wire wr_ptr0   = bus_wr && aw_addr == REG_PTR0;
  wire wr_ptr1   = bus_wr && aw_addr == REG_PTR1;
  wire wr_faddr  = bus_wr && aw_addr == REG_FILE_ADDR;
  wire wr_fdata  = bus_wr && aw_addr == REG_FILE_DATA;

  // address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
    end
    else
    begin
      aw_full <= next_aw;
      w_full  <= next_w;
      awready <= !next_aw && !next_bvalid;
      wready  <= !next_w && !next_bvalid;
    end
  end

  // payload latches
  always_ff @(posedge aclk)
  begin
    if (aw_take)
      aw_addr <= awaddr;
    if (w_take)
    begin
      w_data <= wdata;
      w_strb <= wstrb;
    end
  end

  // write response; refused while busy or unmapped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else
    begin
      bvalid <= next_bvalid;
      if (do_write)
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel, answer one edge after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_take)
      begin
        rdata <= addr_known(araddr) ? reg_view(araddr) : 32'h0;
        rresp <= addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // indirect access port maps through the selected pointer
  wire                is_port  = dec.faddr[FADDR_W-1:1] == PORT_BASE[FADDR_W-1:1];
  wire                port_sel = dec.faddr[0];
  wire [FADDR_W-1:0]  eff_addr = is_port ? ptr[port_sel][FADDR_W-1:0]
                                         : dec.faddr;
  wire                file_op  = dec.kind >= K_SUM && dec.kind <= K_TEST_SET;
  wire                byte_op  = (dec.kind >= K_SUM && dec.kind <= K_ROT_R) ||
                                 dec.kind == K_DEC_SKIP || dec.kind == K_INC_SKIP;
  wire                slow     = (file_op && is_port && ptr[port_sel][PTR_MSB]) ||
                                 (dec.kind == K_PTR_INC &&
                                  ptr[dec.inc_sel][PTR_MSB]);
  wire                flow     = dec.kind == K_FLOW || dec.kind == K_RET_LIT;
  wire                redirect = flow || skip_q;
  wire [1:0]          extra    = {1'b0, redirect} + {1'b0, slow};

  // result routing by destination bit
  wire to_file = (byte_op && dec.dest) || dec.kind == K_STORE_W ||
                 dec.kind == K_BIT_CLR || dec.kind == K_BIT_SET;
  wire to_acc  = byte_op && !dec.dest;

  // flag update set per kind; others leave flags alone
  wire upd_c  = dec.kind == K_SUM || dec.kind == K_SUM_C ||
                dec.kind == K_ROT_L || dec.kind == K_ROT_R;
  wire upd_dc = dec.kind == K_SUM || dec.kind == K_SUM_C;
  wire upd_z  = dec.kind == K_SUM || dec.kind == K_SUM_C ||
                dec.kind == K_CONJ || dec.kind == K_DISJ;

  // quarter-cycle divider; q_end is the instruction-cycle enable
  wire q_end  = busy && phase == LAST_Q;
  wire commit = state == S_EXEC && q_end;

  // file array shares one write port between core and bus
  wire                ram_we    = (commit && to_file) || wr_fdata;
  wire [FADDR_W-1:0]  ram_waddr = commit ? eff_addr : file_addr;
  wire [7:0]          ram_wdata = commit ? result : wr_image[7:0];

  file_ram u_ram (
    .aclk    (aclk),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr_a (eff_addr),
    .raddr_b (file_addr),
    .rdata_a (file_q),
    .rdata_b (bus_q)
  );

  // arithmetic and logic on the read operand
  wire        cin      = dec.kind == K_SUM_C && carry;
  wire [8:0]  sum9     = {1'b0, acc} + {1'b0, operand} + {8'h0, cin};
  wire [4:0]  nib5     = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
  wire [7:0]  bit_mask = 8'h01 << dec.bit_idx;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       skip_now;

  always_comb
  begin
    alu_res  = operand;
    alu_c    = carry;
    skip_now = 1'b0;
    case (dec.kind)
      K_SUM, K_SUM_C:
      begin
        alu_res = sum9[7:0];
        alu_c   = sum9[8];
      end
      K_CONJ:     alu_res = acc & operand;
      K_DISJ:     alu_res = acc | operand;
      K_ROT_L:
      begin
        alu_res = {operand[6:0], carry};
        alu_c   = operand[7];
      end
      K_ROT_R:
      begin
        alu_res = {carry, operand[7:1]};
        alu_c   = operand[0];
      end
      K_STORE_W:  alu_res = acc;
      K_DEC_SKIP:
      begin
        alu_res  = operand - 8'h01;
        skip_now = operand == 8'h01;
      end
      K_INC_SKIP:
      begin
        alu_res  = operand + 8'h01;
        skip_now = operand == 8'hFF;
      end
      K_BIT_CLR:  alu_res = operand & ~bit_mask;
      K_BIT_SET:  alu_res = operand | bit_mask;
      K_TEST_CLR: skip_now = (operand & bit_mask) == 8'h00;
      K_TEST_SET: skip_now = (operand & bit_mask) != 8'h00;
      default:    alu_res = operand;
    endcase
  end

  // sequencer: one instruction cycle, then any extra NOP cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= S_IDLE;
      phase      <= 2'h0;
      extra_left <= 2'h0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          phase <= 2'h0;
          if (wr_instr)
            state <= S_EXEC;
        end
        S_EXEC:
        begin
          phase <= phase + 2'h1;
          if (q_end && extra == 2'h0)
            state <= S_IDLE;
          else if (q_end)
          begin
            state      <= S_EXTRA;
            extra_left <= extra;
          end
        end
        S_EXTRA:
        begin
          phase <= phase + 2'h1;
          if (q_end)
            extra_left <= extra_left - 2'h1;
          if (q_end && extra_left == 2'h1)
            state <= S_IDLE;
        end
      endcase
    end
  end

  // operand read happens for every file instruction, stores included
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      operand <= 8'h00;
    else if (state == S_EXEC && phase == Q_READ)
      operand <= file_q;
  end

  // modify step latches result, flags and skip decision
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result <= 8'h00;
      res_c  <= 1'b0;
      res_dc <= 1'b0;
      res_z  <= 1'b0;
      skip_q <= 1'b0;
    end
    else if (state == S_EXEC && phase == Q_MODIFY)
    begin
      result <= alu_res;
      res_c  <= alu_c;
      res_dc <= nib5[4];
      res_z  <= alu_res == 8'h00;
      skip_q <= skip_now;
    end
  end

  // instruction word; only accepted while idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr <= '0;
    else if (wr_instr)
      instr <= wr_image[WORD_W-1:0];
  end

  // accumulator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acc <= 8'h00;
    else if (wr_acc)
      acc <= wr_image[7:0];
    else if (commit && to_acc)
      acc <= result;
    else if (commit && dec.kind == K_RET_LIT)
      acc <= dec.lit8;
  end

  // status flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      carry <= 1'b0;
      half  <= 1'b0;
      zero  <= 1'b0;
    end
    else if (wr_status)
    begin
      carry <= wr_image[ST_CARRY];
      half  <= wr_image[ST_HALF];
      zero  <= wr_image[ST_ZERO];
    end
    else if (commit)
    begin
      carry <= upd_c ? res_c : carry;
      half  <= upd_dc ? res_dc : half;
      zero  <= upd_z ? res_z : zero;
    end
  end

  // bank and page literals, cycle accounting
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bank          <= 5'h00;
      page          <= 7'h00;
      cycles_last   <= 2'h0;
      redirect_last <= 1'b0;
    end
    else if (commit)
    begin
      bank          <= dec.kind == K_BANK ? dec.bank : bank;
      page          <= dec.kind == K_PAGE ? dec.page : page;
      cycles_last   <= extra + 2'h1;
      redirect_last <= redirect;
    end
  end

  // pointers and bus file address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr[0]    <= 16'h0000;
      ptr[1]    <= 16'h0000;
      file_addr <= '0;
    end
    else
    begin
      if (wr_ptr0)
        ptr[0] <= wr_image[15:0];
      if (wr_ptr1)
        ptr[1] <= wr_image[15:0];
      if (wr_faddr)
        file_addr <= wr_image[FADDR_W-1:0];
    end
  end
endmodule

// ===== verif/decoder_sva.sv
// checker: bus handshake properties at the decoder top ports
// assumes one aclk domain, synchronous active-low aresetn
`timescale 1ns/1ps
module decoder_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  // single domain clocking and reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write channels taken in one cycle
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // read response held until accepted
  sequence r_wait;
    rvalid && !rready;
  endsequence
  AST_BLAT: assert property (wr_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  AST_BHOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_BDROP: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  AST_RLAT: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_RHOLD: assert property (r_wait |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed");
  AST_ARLOW: assert property (rvalid |-> !arready)
    else $error("second read accepted");
  AST_AWLOW: assert property (bvalid |-> !awready && !wready)
    else $error("second write accepted");
  AST_RSTQ: assert property ($rose(aresetn) |-> !(awready || arready || bvalid || rvalid))
    else $error("outputs active after reset");
endmodule
bind mcu_instruction_decoder decoder_sva i_decoder_sva (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
);

// ===== verif/prog_mem.sv
// partner: program memory holding the instruction words of the run
// assumes the bench reads a word combinationally by index
`timescale 1ns/1ps
module prog_mem (
  input wire logic [3:0]  idx,
  output logic     [13:0] word
);
  // one instruction word per scenario
  always_comb
  begin
    case (idx)
      4'h0: word = 14'h0790;
      4'h1: word = 14'h0510;
      4'h2: word = 14'h0D90;
      4'h3: word = 14'h0090;
      4'h4: word = 14'h2ABC;
      4'h5: word = 14'h1A90;
      4'h6: word = 14'h0016;
      4'h7: word = 14'h31D5;
      4'h8: word = 14'h0033;
      default: word = 14'h317A;
    endcase
  end
endmodule

// ===== verif/mcu_instruction_decoder_bench.sv
// bench: register-level scenarios for the instruction decoder
// assumes the decoder register map and a 10 MHz aclk
`timescale 1ns/1ps
module mcu_instruction_decoder_bench
  import decoder_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb, pidx;
  logic [1:0]  bresp, rresp, r;
  logic [13:0] word;
  int          bad_count, num_checks;
  // clock
  initial
  begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  mcu_instruction_decoder i_mcu_instruction_decoder (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready
  );
  prog_mem i_prog_mem (.idx(pidx), .word);
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a wait ran out
  task automatic hang();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    results();
  endtask
  // one write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
      // accept one cycle late so the response has to wait
      if (bvalid) bready <= 1'h1;
    end
    if (n == 50) hang();
  endtask
  // one read
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready)
      begin
        v = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
      // accept one cycle late so the read data has to wait
      if (rvalid) rready <= 1'h1;
    end
    if (n == 50) hang();
  endtask
  // read a register and compare one field
  task automatic fd(input logic [7:0] a, input int lo, input int w, input logic [31:0] e);
    rd(a);
    chk((v >> lo) & ((32'h1 << w) - 32'h1), e);
  endtask
  // poll status until busy drops
  task automatic idle();
    int n;
    for (n = 0; n < 20; n++)
    begin
      rd(REG_STATUS);
      if (v[6] === 1'h0) break;
    end
    if (n == 20) hang();
  endtask
  // fetch a word from program memory and start it
  task automatic go(input logic [3:0] i);
    pidx = i;
    #1;
    wr(REG_INSTR, {18'h0, word});
  endtask
  // scenarios
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, pidx} = 52'h0;
    wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    fd(REG_STATUS, 0, 32, 32'h0);
    wr(REG_ACC, 32'h35);
    wr(REG_FILE_ADDR, 32'h10);
    wr(REG_FILE_DATA, 32'h0F);
    go(4'h0);
    idle();
    fd(REG_FILE_DATA, 0, 8, 32'h44);
    fd(REG_STATUS, 0, 12, 32'h08A);
    fd(REG_FIELDS_A, 0, 14, 32'h847);
    go(4'h1);
    idle();
    fd(REG_ACC, 0, 8, 32'h04);
    fd(REG_FILE_DATA, 0, 8, 32'h44);
    fd(REG_STATUS, 0, 12, 32'h18A);
    wr(REG_STATUS, 32'h7);
    go(4'h2);
    idle();
    fd(REG_FILE_DATA, 0, 8, 32'h89);
    fd(REG_STATUS, 0, 12, 32'h28E);
    go(4'h3);
    idle();
    fd(REG_FILE_DATA, 0, 8, 32'h04);
    fd(REG_STATUS, 0, 12, 32'h38E);
    go(4'h4);
    wr(REG_ACC, 32'hFF);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    idle();
    fd(REG_ACC, 0, 8, 32'h04);
    fd(REG_FIELDS_B, 0, 20, 32'h5E2BC);
    fd(REG_STATUS, 0, 12, 32'h836);
    go(4'h5);
    idle();
    fd(REG_FIELDS_A, 14, 7, 32'h35);
    fd(REG_STATUS, 3, 3, 32'h6);
    wr(REG_PTR1, 32'h8000);
    go(4'h6);
    idle();
    fd(REG_FIELDS_C, 6, 4, 32'hA);
    fd(REG_STATUS, 3, 3, 32'h2);
    go(4'h7);
    idle();
    fd(REG_STATUS, 17, 7, 32'h55);
    fd(REG_FIELDS_A, 21, 8, 32'hD5);
    go(4'h8);
    idle();
    fd(REG_STATUS, 12, 5, 32'h13);
    go(4'h9);
    idle();
    fd(REG_FIELDS_C, 0, 7, 32'h7A);
    rd(8'h28);
    chk({r, v[29:0]}, {RESP_SLVERR, 30'h0});
    results();
  end
endmodule
